//--- shared/hsv_pkg.sv
package hsv_pkg;
    localparam logic [7:0] HSV_OFS_HOT_SWAP = 8'he4;
    localparam logic [7:0] HSV_OFS_PD_ADDR = 8'he8;
    localparam logic [7:0] HSV_OFS_PD_WORD = 8'hec;
    localparam logic [7:0] HSV_OFS_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] HSV_OFS_IRQ_MASK = 8'hf4;
    localparam logic [7:0] HSV_HS_CAP_CODE = 8'h06;
    localparam logic [7:0] HSV_PD_CAP_CODE = 8'h03;
    localparam logic [7:0] HSV_LIST_END = 8'h00;
    localparam int HSV_BIT_INS = 23;
    localparam int HSV_BIT_EXT = 22;
    localparam int HSV_BIT_LIGHT = 19;
    localparam int HSV_BIT_MASK = 17;
    localparam int HSV_BIT_PD_FLAG = 31;
    localparam logic [31:0] HSV_WORD_RESET = 32'h0000_0000;
    localparam logic [7:0] HSV_ADDR_RESET = 8'h00;
    // irq status bits: 0 insertion set, 1 extraction set, 2 eeprom done
    localparam int HSV_NUM_EVENTS = 3;
    // eeprom request to the serial engine
    typedef struct packed {
        logic req;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } hsv_ee_req_t;
endpackage

//--- tb/hot_swap_vpd_capability_tb_top.sv
`timescale 1ns/1ps
module hot_swap_vpd_capability_tb_top
    import hsv_pkg::*;
;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, rdata, q;
    logic ejector = 1'b0, load_done = 1'b0, bus_dis = 1'b1, pd_en = 1'b1, slow = 1'b0;
    logic ee_done, indicator, reconfig, irq;
    hsv_ee_req_t ee;
    int failures = 0;
    int compares = 0;
    hsv_cap_regs hsv_cap_regs_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_ejector_switch(ejector), .i_load_done(load_done), .i_bus_side_disable(bus_dis),
        .i_pd_enable(pd_en), .o_ee(ee), .i_ee_done(ee_done), .i_ee_rdata(rdata),
        .o_indicator_on(indicator), .o_reconfig_irq(reconfig), .o_irq(irq));
    hsv_ee_model hsv_ee_model_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_slow(slow), .i_ee(ee),
        .o_done(ee_done), .o_rdata(rdata));
    always #50 i_ref_clk = ~i_ref_clk;
    ////////////////////////////////////////////////////////////////////////
    // expected hot-swap register image
    function automatic logic [31:0] hs(input int insertion_status, extraction_status, light, mask, input logic [7:0] nxt);
        return {8'h00, insertion_status[0], extraction_status[0], 2'b00, light[0], 1'b0, mask[0], 1'b0, nxt, HSV_HS_CAP_CODE};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge i_ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            failures++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        wb(1'b1, a, d, s);
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask
    // poll the flag; a flag that never turns is a mismatch and ends the run
    task automatic poll(input logic v);
        int n;
        n = 0;
        do
        begin
            rd(HSV_OFS_PD_ADDR);
            n++;
        end
        while (q[31] !== v && n < 40);
        chk("product data flag", {31'h0, v}, {31'h0, q[31]});
        if (q[31] !== v)
            summarize();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        // the enable pin needs two edges through its synchroniser before it reads back
        repeat (3) @(posedge i_ref_clk);
        rd(HSV_OFS_HOT_SWAP); chk("hot swap reset", hs(0, 0, 0, 0, 8'he8), q);
        rd(HSV_OFS_PD_ADDR); chk("pd reset", {8'h00, HSV_ADDR_RESET, HSV_LIST_END, HSV_PD_CAP_CODE}, q);
        rd(HSV_OFS_PD_WORD); chk("pd word reset", HSV_WORD_RESET, q);
        rd(8'h40); chk("unmapped read", 32'h0, q);
        wr(HSV_OFS_PD_ADDR, 32'h0000_ffff, 4'h3);
        rd(HSV_OFS_PD_ADDR); chk("pd read only", 32'h0000_0003, q);
        $display("test reset values done");
        wr(HSV_OFS_HOT_SWAP, 32'h0008_0000);
        pd_en <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        rd(HSV_OFS_HOT_SWAP); chk("list end", hs(0, 0, 1, 0, HSV_LIST_END), q);
        chk("indicator on", 32'h1, {31'h0, indicator});
        pd_en <= 1'b1;
        $display("test indicator and pointer done");
        // insertion held off while the bus side is disabled
        wr(HSV_OFS_IRQ_MASK, 32'h0000_0007);
        load_done <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        rd(HSV_OFS_HOT_SWAP); chk("insertion blocked", hs(0, 0, 1, 0, 8'he8), q);
        bus_dis <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        rd(HSV_OFS_HOT_SWAP); chk("insertion set", hs(1, 0, 1, 0, 8'he8), q);
        chk("reconfig irq", 32'h1, {31'h0, reconfig});
        chk("event irq", 32'h1, {31'h0, irq});
        wr(HSV_OFS_HOT_SWAP, 32'h000a_0000);
        chk("reconfig masked", 32'h0, {31'h0, reconfig});
        wr(HSV_OFS_HOT_SWAP, 32'h0088_0000);
        rd(HSV_OFS_HOT_SWAP); chk("insertion cleared", hs(0, 0, 1, 0, 8'he8), q);
        wr(HSV_OFS_IRQ_STATUS, 32'h0000_0001);
        chk("event irq cleared", 32'h0, {31'h0, irq});
        $display("test insertion done");
        ejector <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        rd(HSV_OFS_HOT_SWAP); chk("extraction set", hs(0, 1, 1, 0, 8'he8), q);
        chk("reconfig ext", 32'h1, {31'h0, reconfig});
        ejector <= 1'b0;
        wr(HSV_OFS_HOT_SWAP, 32'h0040_0000);
        rd(HSV_OFS_HOT_SWAP); chk("extraction cleared", hs(0, 0, 0, 0, 8'he8), q);
        chk("indicator off", 32'h0, {31'h0, indicator});
        wr(HSV_OFS_IRQ_STATUS, 32'h0000_0007);
        $display("test extraction done");
        // word loaded first, then the write started at an unaligned address
        wr(HSV_OFS_PD_WORD, 32'h1234_56a5);
        wr(HSV_OFS_PD_ADDR, 32'h8013_0000, 4'hc);
        poll(1'b0);
        rd(HSV_OFS_PD_ADDR); chk("pd address aligned", 32'h0010_0003, q);
        chk("eeprom word", 32'h1234_56a5, hsv_ee_model_inst.mem[4]);
        $display("test eeprom write done");
        slow <= 1'b1;
        wr(HSV_OFS_PD_WORD, 32'h0000_0000);
        wr(HSV_OFS_PD_ADDR, 32'h0010_0000, 4'hc);
        poll(1'b1);
        rd(HSV_OFS_PD_WORD); chk("pd word read", 32'h1234_56a5, q);
        chk("pd low byte", 32'h0000_00a5, {24'h0, q[7:0]});
        rd(HSV_OFS_IRQ_STATUS); chk("done event", 32'h0000_0004, q);
        $display("test eeprom read done");
        summarize();
    end
endmodule

//--- tb/hsv_ee_model.sv
`timescale 1ns/1ps
// behavioural serial eeprom engine, word wide, answers after 0 or 6 wait cycles
module hsv_ee_model
    import hsv_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_slow,
    input wire hsv_ee_req_t i_ee,
    output logic o_done,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [0:63];
    logic [3:0] cnt;
    ////////////////////////////////////////////////////////////////////////
    // read data is only valid with done; otherwise it toggles so stale values never pass
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_done <= 1'b0;
            o_rdata <= 32'h0000_0000;
            cnt <= 4'h0;
        end
        else
        begin
            o_done <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_ee.req && !o_done)
            begin
                if (cnt == (i_slow ? 4'h6 : 4'h0))
                begin
                    cnt <= 4'h0;
                    o_done <= 1'b1;
                    if (i_ee.wr)
                        mem[i_ee.addr[7:2]] <= i_ee.wdata;
                    else
                        o_rdata <= mem[i_ee.addr[7:2]];
                end
                else
                    cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

//--- verilog/hsv_cap_regs.sv
`timescale 1ns/1ps
// hot-swap and product data capability registers on classic wishbone
module hsv_cap_regs
    import hsv_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_ejector_switch,
    input wire logic i_load_done,
    input wire logic i_bus_side_disable,
    input wire logic i_pd_enable,
    output hsv_ee_req_t o_ee,
    input wire logic i_ee_done,
    input wire logic [31:0] i_ee_rdata,
    output logic o_indicator_on,
    output logic o_reconfig_irq,
    output logic o_irq
);
    logic insertion_status;
    logic extraction_status;
    logic light;
    logic mask;
    logic pd_flag;
    logic [7:0] pd_addr;
    logic [31:0] pd_word;
    logic ee_busy;
    logic ee_wr;
    logic [HSV_NUM_EVENTS-1:0] irq_status;
    logic [HSV_NUM_EVENTS-1:0] irq_mask;
    logic [HSV_NUM_EVENTS-1:0] ev;
    logic sw_rise, ld_lvl, ld_rise, dis_lvl, en_lvl;
    logic ins_prev;
    logic ins_set;
    genvar lane;
    genvar ev_i;
    logic wr_cyc;
    logic [31:0] next_rdata;
    logic [31:0] wmask;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    hsv_event_sync u_sw (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_ejector_switch),
        .o_level(), .o_rise(sw_rise));
    hsv_event_sync u_ld (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_load_done),
        .o_level(ld_lvl), .o_rise(ld_rise));
    hsv_event_sync u_dis (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_bus_side_disable),
        .o_level(dis_lvl), .o_rise());
    hsv_event_sync u_en (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_pd_enable),
        .o_level(en_lvl), .o_rise());

    ////////////////////////////////////////////////////////////////////
    // bus decode; ack is one cycle, then dropped so each access acks once
    assign wr_cyc = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign wmask[lane*8 +: 8] = {8{i_wb_sel[lane]}};
        end
    endgenerate

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_wb_ack <= 1'b0;
        else
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
    end

    ////////////////////////////////////////////////////////////////////
    // insertion set term: load done with the bus side enabled, once per load
    assign ins_set = ld_lvl & ~dis_lvl & (ld_rise | ~ins_prev);

    // insertion and extraction flags, set wins over write-one-clear
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            insertion_status <= 1'b0;
            extraction_status <= 1'b0;
        end
        else
        begin
            if (ins_set)
                insertion_status <= 1'b1;
            else if (wr_cyc && i_wb_adr == HSV_OFS_HOT_SWAP && i_wb_sel[2] && i_wb_dat[HSV_BIT_INS])
                insertion_status <= 1'b0;
            if (sw_rise)
                extraction_status <= 1'b1; // reset holds the syncs low, so rst negated is implied
            else if (wr_cyc && i_wb_adr == HSV_OFS_HOT_SWAP && i_wb_sel[2] && i_wb_dat[HSV_BIT_EXT])
                extraction_status <= 1'b0;
        end
    end

    // insertion fires once per load completion, not again after a clear
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ins_prev <= 1'b0;
        else if (ld_lvl && !dis_lvl)
            ins_prev <= 1'b1;
        else if (!ld_lvl)
            ins_prev <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // light and mask control bits
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            light <= 1'b0;
            mask <= 1'b0;
        end
        else if (wr_cyc && i_wb_adr == HSV_OFS_HOT_SWAP && i_wb_sel[2])
        begin
            light <= i_wb_dat[HSV_BIT_LIGHT];
            mask <= i_wb_dat[HSV_BIT_MASK];
        end
    end

    assign o_indicator_on = light;
    assign o_reconfig_irq = (insertion_status | extraction_status) & ~mask;

    ////////////////////////////////////////////////////////////////////
    // product data address, flag and eeprom sequencing
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pd_flag <= 1'b0;
            pd_addr <= HSV_ADDR_RESET;
            ee_busy <= 1'b0;
            ee_wr <= 1'b0;
        end
        else if (ee_busy)
        begin
            // writes to the address register are ignored until the access ends
            if (i_ee_done)
            begin
                ee_busy <= 1'b0;
                pd_flag <= ~ee_wr;
            end
        end
        else if (wr_cyc && i_wb_adr == HSV_OFS_PD_ADDR)
        begin
            if (i_wb_sel[2])
                pd_addr <= {i_wb_dat[23:18], 2'b00}; // word aligned
            if (i_wb_sel[3])
            begin
                pd_flag <= i_wb_dat[HSV_BIT_PD_FLAG];
                ee_wr <= i_wb_dat[HSV_BIT_PD_FLAG];
                ee_busy <= 1'b1;
            end
        end
    end

    assign o_ee.req = ee_busy;
    assign o_ee.wr = ee_wr;
    assign o_ee.addr = pd_addr;
    assign o_ee.wdata = pd_word;

    // data word: eeprom word at the address lands in bits 31:0
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            pd_word <= HSV_WORD_RESET;
        else if (ee_busy && i_ee_done && !ee_wr)
            pd_word <= i_ee_rdata;
        else if (wr_cyc && i_wb_adr == HSV_OFS_PD_WORD)
            pd_word <= (pd_word & ~wmask) | (i_wb_dat & wmask);
    end

    ////////////////////////////////////////////////////////////////////
    // sticky interrupt status, one flop per event, write one to clear, set wins
    // insertion event uses the flag's own set term, so a late bus enable still raises it
    assign ev = {ee_busy & i_ee_done, sw_rise, ins_set};
    generate
        for (ev_i = 0; ev_i < HSV_NUM_EVENTS; ev_i++)
        begin : g_event
            always_ff @(posedge i_ref_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                    irq_status[ev_i] <= 1'b0;
                else if (ev[ev_i])
                    irq_status[ev_i] <= 1'b1;
                else if (wr_cyc && i_wb_adr == HSV_OFS_IRQ_STATUS && i_wb_sel[0] && i_wb_dat[ev_i])
                    irq_status[ev_i] <= 1'b0;
            end
        end
    endgenerate

    // interrupt enables, a one lets the matching status bit through
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            irq_mask <= '0;
        else if (wr_cyc && i_wb_adr == HSV_OFS_IRQ_MASK && i_wb_sel[0])
            irq_mask <= i_wb_dat[HSV_NUM_EVENTS-1:0];
    end

    assign o_irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (i_wb_adr)
            HSV_OFS_HOT_SWAP:
            begin
                next_rdata[HSV_BIT_INS] = insertion_status;
                next_rdata[HSV_BIT_EXT] = extraction_status;
                next_rdata[HSV_BIT_LIGHT] = light;
                next_rdata[HSV_BIT_MASK] = mask;
                next_rdata[15:8] = en_lvl ? HSV_OFS_PD_ADDR : HSV_LIST_END;
                next_rdata[7:0] = HSV_HS_CAP_CODE;
            end
            HSV_OFS_PD_ADDR:
            begin
                next_rdata[HSV_BIT_PD_FLAG] = pd_flag;
                next_rdata[23:16] = pd_addr;
                next_rdata[15:8] = HSV_LIST_END;
                next_rdata[7:0] = HSV_PD_CAP_CODE;
            end
            HSV_OFS_PD_WORD: next_rdata = pd_word;
            HSV_OFS_IRQ_STATUS: next_rdata[HSV_NUM_EVENTS-1:0] = irq_status;
            HSV_OFS_IRQ_MASK: next_rdata[HSV_NUM_EVENTS-1:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_wb_dat <= 32'h0000_0000;
        else
            o_wb_dat <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    irq_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_reconfig_irq == ((insertion_status | extraction_status) && !mask))
        else $error("irq mismatch");
    ext_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        sw_rise |=> extraction_status)
        else $error("extraction not set");
    ins_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ld_rise && !dis_lvl) |=> insertion_status)
        else $error("insertion not set");
    wr_done_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ee_busy && ee_wr && i_ee_done) |=> !pd_flag && !ee_busy)
        else $error("write end");
    rd_done_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ee_busy && !ee_wr && i_ee_done) |=> pd_flag && pd_word == $past(i_ee_rdata))
        else $error("read end");
    addr_align_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        pd_addr[1:0] == 2'b00)
        else $error("addr unaligned");
    next_ptr_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_wb_adr == HSV_OFS_HOT_SWAP && i_wb_stb && !o_wb_ack) |=> o_wb_dat[15:8] == ($past(en_lvl) ? 8'he8 : 8'h00))
        else $error("next ptr");
    light_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (wr_cyc && i_wb_adr == HSV_OFS_HOT_SWAP && i_wb_sel[2]) |=> o_indicator_on == $past(i_wb_dat[19]))
        else $error("light");
    pd_ids_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_wb_adr == HSV_OFS_PD_ADDR && i_wb_stb && !o_wb_ack) |=> o_wb_dat[15:0] == 16'h0003)
        else $error("pd ids");
    hs_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_wb_adr == HSV_OFS_HOT_SWAP && i_wb_stb && !o_wb_ack) |=> o_wb_dat[7:0] == 8'h06)
        else $error("hs code");
    mask_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        mask |-> !o_reconfig_irq)
        else $error("masked irq raised");
    ins_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (wr_cyc && i_wb_adr == HSV_OFS_HOT_SWAP && i_wb_sel[2] && i_wb_dat[23] && !ins_set) |=> !insertion_status)
        else $error("insertion not cleared");
    ext_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (wr_cyc && i_wb_adr == HSV_OFS_HOT_SWAP && i_wb_sel[2] && i_wb_dat[22] && !sw_rise) |=> !extraction_status)
        else $error("extraction not cleared");
    insert_event_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        ins_set |=> insertion_status && irq_status[0])
        else $error("insertion event lost");
    access_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (wr_cyc && i_wb_adr == HSV_OFS_PD_ADDR && i_wb_sel[3] && !ee_busy) |=> ee_busy && ee_wr == $past(i_wb_dat[31]))
        else $error("access not started");
    addr_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ee_busy && !i_ee_done) |=> $stable(pd_addr) && $stable(ee_wr))
        else $error("access changed mid way");
    low_byte_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ee_busy && !ee_wr && i_ee_done) |=> pd_word[7:0] == $past(i_ee_rdata[7:0]))
        else $error("low byte");
    ack_next_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
        else $error("ack late");
    ack_once_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held");
endmodule

//--- verilog/hsv_event_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser with a rising edge pulse on the clean side
module hsv_event_sync
    import hsv_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_async,
    output logic o_level,
    output logic o_rise
);
    logic meta;
    logic sync;
    logic last;

    // meta feeds only the second stage
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            meta <= i_async;
            sync <= meta;
            last <= sync;
        end
    end

    assign o_level = sync;
    assign o_rise = sync & ~last;
endmodule
